// >>> inc/sbm_pkg.sv
// Shared constants, types and address decoding for the sequencer bus master port.
// Assumes one 100 MHz cluster bus clock shared by both ends of the link.
package sbm_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int THR_W = 3;

	// Address map of the cluster register bus.
	localparam logic [3:0] CNV_PAGE = 4'hF;
	localparam logic [3:0] PROC_ONLY_PAGE = 4'hE;
	localparam logic [3:0] MULTI_WAIT_PAGE = 4'hD;
	localparam logic [7:0] ONE_WAIT_PAGE = 8'h00;

	// Wait cycles per class of target.
	localparam logic [3:0] WAIT_ZERO = 4'h0;
	localparam logic [3:0] WAIT_ONE = 4'h1;
	localparam logic [3:0] WAIT_MULTI = 4'h2;

	// Reset values.
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

	typedef enum logic [2:0] {
		SBM_CLS_ZERO = 3'b000,
		SBM_CLS_ONE = 3'b001,
		SBM_CLS_MULTI = 3'b010,
		SBM_CLS_PROC_ONLY = 3'b011,
		SBM_CLS_CNV = 3'b100
	} sbm_class_t;

	function automatic sbm_class_t sbm_decode(input logic [ADDR_W-1:0] a);
		sbm_class_t c;
		c = SBM_CLS_ZERO;
		if (a[15:12] == CNV_PAGE) begin
			c = SBM_CLS_CNV;
		end else if (a[15:12] == PROC_ONLY_PAGE) begin
			c = SBM_CLS_PROC_ONLY;
		end else if (a[15:12] == MULTI_WAIT_PAGE) begin
			c = SBM_CLS_MULTI;
		end else if (a[15:8] == ONE_WAIT_PAGE) begin
			c = SBM_CLS_ONE;
		end
		return c;
	endfunction

	function automatic logic [3:0] sbm_waits(input sbm_class_t c);
		logic [3:0] w;
		w = WAIT_ZERO;
		case (c)
			SBM_CLS_ONE: begin
				w = WAIT_ONE;
			end
			SBM_CLS_MULTI, SBM_CLS_PROC_ONLY: begin
				w = WAIT_MULTI;
			end
			default: begin
				w = WAIT_ZERO;
			end
		endcase
		return w;
	endfunction

endpackage

// >>> inc/sbm_link_if.sv
// Link between the sequencer end and the bus master port end.
// Both ends run on clk_sys; the testbench instantiates and joins them.
`timescale 1ns/100ps
interface sbm_link_if;
	import sbm_pkg::*;
	logic req_valid;
	logic req_ready;
	logic req_we;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_wdata;
	logic [THR_W-1:0] req_thread;
	logic rsp_valid;
	logic [DATA_W-1:0] rsp_rdata;
	logic rsp_err;
	logic [THR_W-1:0] rsp_thread;
	logic cnv_valid;
	logic [DATA_W-1:0] cnv_rdata;
	logic [THR_W-1:0] cnv_thread;
	logic port_disable;

	modport dev (
		input req_valid, req_we, req_addr, req_wdata, req_thread, port_disable,
		output req_ready, rsp_valid, rsp_rdata, rsp_err, rsp_thread,
		output cnv_valid, cnv_rdata, cnv_thread
	);
	modport seq (
		output req_valid, req_we, req_addr, req_wdata, req_thread, port_disable,
		input req_ready, rsp_valid, rsp_rdata, rsp_err, rsp_thread,
		input cnv_valid, cnv_rdata, cnv_thread
	);
endinterface

// >>> verilog/sbm_seq_end.sv
// Sequencer end: issues one register-bus or converter access at a time.
// Assumes the master port end on the same link and the same clock.
`timescale 1ns/100ps
module sbm_seq_end (
	input wire logic clk_sys,
	input wire logic rst_n,
	sbm_link_if.seq link,
	input wire logic usr_req,
	input wire logic usr_we,
	input wire logic [sbm_pkg::ADDR_W-1:0] usr_addr,
	input wire logic [sbm_pkg::DATA_W-1:0] usr_wdata,
	input wire logic [sbm_pkg::THR_W-1:0] usr_thread,
	input wire logic usr_cnv_only,
	input wire logic usr_disable,
	output logic usr_busy,
	output logic usr_done,
	output logic usr_err,
	output logic [sbm_pkg::DATA_W-1:0] usr_rdata
);
	import sbm_pkg::*;

	typedef enum logic [1:0] {
		SBM_S_IDLE = 2'b00,
		SBM_S_REQ = 2'b01,
		SBM_S_WAIT = 2'b10
	} sbm_seq_state_t;

	sbm_seq_state_t state_q, state_d;
	logic valid_q, valid_d;
	logic we_q, we_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [THR_W-1:0] thr_q, thr_d;
	logic dis_q, dis_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic err_q, err_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic cnv_req;

	assign cnv_req = (sbm_decode(usr_addr) == SBM_CLS_CNV) && !usr_we;

	always_comb begin
		state_d = state_q;
		valid_d = valid_q;
		we_d = we_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		thr_d = thr_q;
		busy_d = busy_q;
		done_d = 1'b0;
		err_d = 1'b0;
		rdata_d = rdata_q;
		// The disable only ever latches; it is never released. [RULE12]
		dis_d = dis_q | usr_disable;
		case (state_q)
			SBM_S_IDLE: begin
				if (usr_req) begin
					if (dis_q || (usr_cnv_only && !cnv_req)) begin
						// Converter-only mode refuses bus traffic. [RULE15]
						done_d = 1'b1;
						err_d = 1'b1;
					end else begin
						// A single outstanding access keeps one buffer at most. [RULE11] [RULE13]
						state_d = SBM_S_REQ;
						valid_d = 1'b1;
						busy_d = 1'b1;
						we_d = usr_we;
						addr_d = usr_addr;
						wdata_d = usr_wdata;
						thr_d = usr_thread;
					end
				end
			end
			SBM_S_REQ: begin
				if (link.req_ready) begin
					valid_d = 1'b0;
					state_d = SBM_S_WAIT;
				end
			end
			SBM_S_WAIT: begin
				// Ownership is kept until the completion comes back. [RULE14]
				if (link.rsp_valid && link.rsp_thread == thr_q) begin
					state_d = SBM_S_IDLE;
					busy_d = 1'b0;
					done_d = 1'b1;
					err_d = link.rsp_err;
					rdata_d = link.rsp_rdata;
				end else if (link.cnv_valid && link.cnv_thread == thr_q) begin
					state_d = SBM_S_IDLE;
					busy_d = 1'b0;
					done_d = 1'b1;
					rdata_d = link.cnv_rdata;
				end
			end
			default: begin
				state_d = SBM_S_IDLE;
				valid_d = 1'b0;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SBM_S_IDLE;
			valid_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= ADDR_RST;
			wdata_q <= DATA_RST;
			thr_q <= '0;
			dis_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= DATA_RST;
		end else begin
			state_q <= state_d;
			valid_q <= valid_d;
			we_q <= we_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			thr_q <= thr_d;
			dis_q <= dis_d;
			busy_q <= busy_d;
			done_q <= done_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end

	assign link.req_valid = valid_q;
	assign link.req_we = we_q;
	assign link.req_addr = addr_q;
	assign link.req_wdata = wdata_q;
	assign link.req_thread = thr_q;
	assign link.port_disable = dis_q;
	assign usr_busy = busy_q;
	assign usr_done = done_q;
	assign usr_err = err_q;
	assign usr_rdata = rdata_q;
endmodule

// >>> verilog/sbm_master_port.sv
// Port and cluster bus mux: request buffers, converter bypass, arbiter.
// Assumes bus and converter read data stand in the last request cycle.
`timescale 1ns/100ps
// What this block does
// RULE1: Mux arbitrates processor and sequencer bus accesses.
// RULE2: Sequencer requests win over processor by default.
// RULE3: Access lasts one plus wait cycles of target.
// RULE4: Ordinary registers and converter reads take zero waits.
// RULE5: Special control registers take exactly one wait.
// RULE6: Memories and trigger registers take multiple waits.
// RULE7: Delayed sequencer requests wait in port buffers.
// RULE8: Converter range recognised and sent to converter.
// RULE9: Converter reads bypass buffers with zero wait.
// RULE10: Buffered access runs right after processor access.
// RULE11: Sender never fills more than one buffer.
// RULE12: Port disable is permanent, never toggled.
// RULE13: One channel per sequencer uses port.
// RULE14: Token holder keeps token until access completes.
// RULE15: Converter-only mode allows all channels reads.
// RULE16: Routing unit traffic is independent of port.
// RULE17: Queue and sequencer memory refused from sequencer.
// RULE18: Queued requests complete once, with correct data.
module sbm_master_port #(
	parameter int NBUF = 2,
	parameter logic [3:0] MULTI_WAITS = sbm_pkg::WAIT_MULTI
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	sbm_link_if.dev link,
	input wire logic cpu_priority,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [sbm_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic [sbm_pkg::DATA_W-1:0] cpu_wdata,
	output logic cpu_done,
	output logic [sbm_pkg::DATA_W-1:0] cpu_rdata,
	output logic bus_req,
	output logic bus_we,
	output logic [sbm_pkg::ADDR_W-1:0] bus_addr,
	output logic [sbm_pkg::DATA_W-1:0] bus_wdata,
	input wire logic [sbm_pkg::DATA_W-1:0] bus_rdata,
	output logic cnv_rd,
	output logic [sbm_pkg::ADDR_W-1:0] cnv_addr,
	input wire logic [sbm_pkg::DATA_W-1:0] cnv_rdata
);
	import sbm_pkg::*;
	localparam int PTR_W = (NBUF > 1) ? $clog2(NBUF) : 1;
	localparam logic [PTR_W:0] NBUF_C = (PTR_W+1)'(NBUF);
	typedef enum logic [1:0] {
		SBM_M_IDLE = 2'b00,
		SBM_M_BUSY = 2'b01
	} sbm_mux_state_t;
	// Request buffers; the routing unit has no path through here. [RULE16]
	logic buf_we_mem [NBUF];
	logic [ADDR_W-1:0] buf_addr_mem [NBUF];
	logic [DATA_W-1:0] buf_wdata_mem [NBUF];
	logic [THR_W-1:0] buf_thr_mem [NBUF];
	logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
	logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
	logic [PTR_W:0] count_q, count_d;
	logic ready_q, ready_d;
	logic push;
	logic pop;
	logic accept;
	logic req_is_cnv;
	sbm_mux_state_t state_q, state_d;
	logic owner_seq_q, owner_seq_d;
	logic [3:0] cnt_q, cnt_d;
	logic bus_req_q, bus_req_d;
	logic bus_we_q, bus_we_d;
	logic [ADDR_W-1:0] bus_addr_q, bus_addr_d;
	logic [DATA_W-1:0] bus_wdata_q, bus_wdata_d;
	logic [THR_W-1:0] cur_thr_q, cur_thr_d;
	logic cpu_done_q, cpu_done_d;
	logic [DATA_W-1:0] cpu_rdata_q, cpu_rdata_d;
	logic rsp_valid_q, rsp_valid_d;
	logic rsp_err_q, rsp_err_d;
	logic [DATA_W-1:0] rsp_rdata_q, rsp_rdata_d;
	logic [THR_W-1:0] rsp_thr_q, rsp_thr_d;
	logic cnv_rd_q, cnv_rd_d;
	logic [ADDR_W-1:0] cnv_addr_q, cnv_addr_d;
	logic [THR_W-1:0] cnv_thr_q, cnv_thr_d;
	logic cnv_valid_q, cnv_valid_d;
	logic [DATA_W-1:0] cnv_data_q, cnv_data_d;
	logic [THR_W-1:0] cnv_rthr_q, cnv_rthr_d;
	sbm_class_t head_cls;
	logic cpu_pend;
	function automatic logic [3:0] class_waits(input sbm_class_t c);
		return (c == SBM_CLS_MULTI || c == SBM_CLS_PROC_ONLY) ?
			MULTI_WAITS : sbm_waits(c);
	endfunction
	// Converter reads are found by their address page. [RULE8]
	assign req_is_cnv = (sbm_decode(link.req_addr) == SBM_CLS_CNV);
	assign accept = link.req_valid && ready_q;
	assign push = accept && !req_is_cnv;
	assign head_cls = sbm_decode(buf_addr_mem[rd_ptr_q]);
	// A processor request is not retaken in the cycle its completion shows.
	assign cpu_pend = cpu_req && !cpu_done_q;
	// Converter reads go out at once and answer the next cycle. [RULE9]
	always_comb begin
		cnv_rd_d = accept && req_is_cnv;
		cnv_addr_d = (accept && req_is_cnv) ? link.req_addr : cnv_addr_q;
		cnv_thr_d = (accept && req_is_cnv) ? link.req_thread : cnv_thr_q;
		cnv_valid_d = cnv_rd_q;
		cnv_data_d = cnv_rd_q ? cnv_rdata : cnv_data_q;
		cnv_rthr_d = cnv_rd_q ? cnv_thr_q : cnv_rthr_q;
	end
	always_comb begin
		state_d = state_q;
		owner_seq_d = owner_seq_q;
		cnt_d = cnt_q;
		bus_req_d = bus_req_q;
		bus_we_d = bus_we_q;
		bus_addr_d = bus_addr_q;
		bus_wdata_d = bus_wdata_q;
		cur_thr_d = cur_thr_q;
		cpu_done_d = 1'b0;
		cpu_rdata_d = cpu_rdata_q;
		rsp_valid_d = 1'b0;
		rsp_err_d = 1'b0;
		rsp_rdata_d = rsp_rdata_q;
		rsp_thr_d = rsp_thr_q;
		pop = 1'b0;
		case (state_q)
			SBM_M_IDLE: begin
				// Sequencer first unless processor priority is chosen. [RULE1] [RULE2]
				if (count_q != '0 && (!cpu_priority || !cpu_pend)) begin
					pop = 1'b1;
					rsp_thr_d = buf_thr_mem[rd_ptr_q];
					if (head_cls == SBM_CLS_PROC_ONLY) begin
						// Refused with an error and never put on the bus. [RULE17]
						rsp_valid_d = 1'b1;
						rsp_err_d = 1'b1;
						rsp_rdata_d = DATA_RST;
					end else begin
						state_d = SBM_M_BUSY;
						owner_seq_d = 1'b1;
						cnt_d = class_waits(head_cls); // [RULE3] [RULE4] [RULE5] [RULE6]
						bus_req_d = 1'b1;
						bus_we_d = buf_we_mem[rd_ptr_q];
						bus_addr_d = buf_addr_mem[rd_ptr_q];
						bus_wdata_d = buf_wdata_mem[rd_ptr_q];
						cur_thr_d = buf_thr_mem[rd_ptr_q];
					end
				end else if (cpu_pend) begin
					state_d = SBM_M_BUSY;
					owner_seq_d = 1'b0;
					cnt_d = class_waits(sbm_decode(cpu_addr)); // [RULE3]
					bus_req_d = 1'b1;
					bus_we_d = cpu_we;
					bus_addr_d = cpu_addr;
					bus_wdata_d = cpu_wdata;
				end
			end
			SBM_M_BUSY: begin
				if (cnt_q != WAIT_ZERO) begin
					cnt_d = cnt_q - 4'h1;
				end else begin
					// Back to idle, so a buffered access starts next cycle. [RULE10]
					state_d = SBM_M_IDLE;
					bus_req_d = 1'b0;
					if (owner_seq_q) begin
						rsp_valid_d = 1'b1;
						rsp_rdata_d = bus_we_q ? DATA_RST : bus_rdata;
						rsp_thr_d = cur_thr_q;
					end else begin
						cpu_done_d = 1'b1;
						cpu_rdata_d = bus_we_q ? DATA_RST : bus_rdata;
					end
				end
			end
			default: begin
				state_d = SBM_M_IDLE;
				bus_req_d = 1'b0;
			end
		endcase
	end
	// Pointers move once per push or pop, so nothing is lost or repeated. [RULE7] [RULE18]
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push) begin
			wr_ptr_d = (wr_ptr_q == PTR_W'(NBUF - 1)) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == PTR_W'(NBUF - 1)) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
		// Ready is registered, so it promises room for one more next cycle.
		ready_d = !link.port_disable && (count_d < NBUF_C);
	end
	always_ff @(posedge clk_sys) begin
		if (push) begin
			buf_we_mem[wr_ptr_q] <= link.req_we;
			buf_addr_mem[wr_ptr_q] <= link.req_addr;
			buf_wdata_mem[wr_ptr_q] <= link.req_wdata;
			buf_thr_mem[wr_ptr_q] <= link.req_thread;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			ready_q <= 1'b0;
			state_q <= SBM_M_IDLE;
			owner_seq_q <= 1'b0;
			cnt_q <= WAIT_ZERO;
			bus_req_q <= 1'b0;
			bus_we_q <= 1'b0;
			bus_addr_q <= ADDR_RST;
			bus_wdata_q <= DATA_RST;
			cur_thr_q <= '0;
			cpu_done_q <= 1'b0;
			cpu_rdata_q <= DATA_RST;
			rsp_valid_q <= 1'b0;
			rsp_err_q <= 1'b0;
			rsp_rdata_q <= DATA_RST;
			rsp_thr_q <= '0;
			cnv_rd_q <= 1'b0;
			cnv_addr_q <= ADDR_RST;
			cnv_thr_q <= '0;
			cnv_valid_q <= 1'b0;
			cnv_data_q <= DATA_RST;
			cnv_rthr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
			ready_q <= ready_d;
			state_q <= state_d;
			owner_seq_q <= owner_seq_d;
			cnt_q <= cnt_d;
			bus_req_q <= bus_req_d;
			bus_we_q <= bus_we_d;
			bus_addr_q <= bus_addr_d;
			bus_wdata_q <= bus_wdata_d;
			cur_thr_q <= cur_thr_d;
			cpu_done_q <= cpu_done_d;
			cpu_rdata_q <= cpu_rdata_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_err_q <= rsp_err_d;
			rsp_rdata_q <= rsp_rdata_d;
			rsp_thr_q <= rsp_thr_d;
			cnv_rd_q <= cnv_rd_d;
			cnv_addr_q <= cnv_addr_d;
			cnv_thr_q <= cnv_thr_d;
			cnv_valid_q <= cnv_valid_d;
			cnv_data_q <= cnv_data_d;
			cnv_rthr_q <= cnv_rthr_d;
		end
	end
	assign link.req_ready = ready_q;
	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_err = rsp_err_q;
	assign link.rsp_rdata = rsp_rdata_q;
	assign link.rsp_thread = rsp_thr_q;
	assign link.cnv_valid = cnv_valid_q;
	assign link.cnv_rdata = cnv_data_q;
	assign link.cnv_thread = cnv_rthr_q;
	assign cpu_done = cpu_done_q;
	assign cpu_rdata = cpu_rdata_q;
	assign bus_req = bus_req_q;
	assign bus_we = bus_we_q;
	assign bus_addr = bus_addr_q;
	assign bus_wdata = bus_wdata_q;
	assign cnv_rd = cnv_rd_q;
	assign cnv_addr = cnv_addr_q;
endmodule

// >>> testbench/sbm_link_props.sv
// Checker for the link that joins the sequencer end and the port end.
// Assumes the sequencer end keeps at most one access outstanding.
`timescale 1ns/100ps
module sbm_link_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [sbm_pkg::ADDR_W-1:0] req_addr,
	input wire logic [sbm_pkg::THR_W-1:0] req_thread,
	input wire logic rsp_valid,
	input wire logic [sbm_pkg::DATA_W-1:0] rsp_rdata,
	input wire logic rsp_err,
	input wire logic [sbm_pkg::THR_W-1:0] rsp_thread,
	input wire logic cnv_valid,
	input wire logic [sbm_pkg::THR_W-1:0] cnv_thread,
	input wire logic port_disable
);
	import sbm_pkg::*;
	logic take_cnv;
	logic take_mem;
	logic take_bus;
	logic [THR_W-1:0] thr_d;
	logic [THR_W-1:0] thr_q;
	assign take_cnv = req_valid && req_ready && req_addr[15:12] == CNV_PAGE;
	assign take_mem = req_valid && req_ready
		&& req_addr[15:12] == PROC_ONLY_PAGE;
	assign take_bus = req_valid && req_ready && !take_cnv && !take_mem;
	// Only one access is outstanding, so one thread register is enough.
	always_comb begin
		thr_d = thr_q;
		if (take_bus || take_mem) begin
			thr_d = req_thread;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			thr_q <= 3'h0;
		end else begin
			thr_q <= thr_d;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_cnv_zero_wait: assert property (
		take_cnv |-> ##2 (cnv_valid && cnv_thread == $past(req_thread, 2))
	) else $error("converter answer late or wrong thread");
	a_cnv_one_pulse: assert property (
		cnv_valid |=> !cnv_valid
	) else $error("converter answer longer than one cycle");
	a_bus_latency: assert property (
		take_bus |=> (!rsp_valid)[*2] ##[1:38] (rsp_valid && !rsp_err)
	) else $error("bus answer too early, too late or refused");
	a_mem_refused: assert property (
		take_mem |-> ##2 (rsp_valid && rsp_err)
	) else $error("memory request from sequencer not refused");
	a_err_no_data: assert property (
		rsp_valid && rsp_err |-> rsp_rdata == 32'h00000000
	) else $error("refused access returned data");
	a_rsp_once: assert property (
		rsp_valid |=> !rsp_valid
	) else $error("completion repeated");
	a_rsp_thread: assert property (
		rsp_valid |-> rsp_thread == thr_q
	) else $error("completion carries wrong thread");
	a_disable_stops: assert property (
		port_disable |=> !req_ready
	) else $error("port still ready while disabled");
	a_req_held: assert property (
		req_valid && !req_ready |=>
			req_valid && $stable(req_addr) && $stable(req_thread)
	) else $error("request changed before it was taken");
endmodule

// >>> testbench/sbm_master_port_tb_top.sv
// Testbench top: joins both ends over the link and drives their user sides.
// Assumes a behavioural bus target and converter answering from the bench.
`timescale 1ns/100ps
module sbm_master_port_tb_top;
	import sbm_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic usr_req = 1'b0, usr_we = 1'b0, usr_cnv_only = 1'b0;
	logic usr_disable = 1'b0, usr_busy, usr_done, usr_err;
	logic [15:0] usr_addr = 16'h0000;
	logic [31:0] usr_wdata = 32'h00000000, usr_rdata;
	logic [2:0] usr_thread = 3'h0;
	logic cpu_priority = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, cpu_done;
	logic [15:0] cpu_addr = 16'h0000, bus_addr, cnv_addr;
	logic [31:0] cpu_wdata = 32'h00000000, cpu_rdata, bus_wdata;
	logic [31:0] bus_rdata, cnv_rdata, lb_wdata;
	logic bus_req, bus_we, cnv_rd, lb_we;
	int fails = 0, total_checks = 0, run = 0, gap = 0, last_len = 0;
	int nbus = 0, ncnv = 0, gq[$];
	logic [15:0] hist[$];
	sbm_link_if link();
	always #5 clk_sys = ~clk_sys;
	// Released lines show a pattern, never the last value.
	assign bus_rdata = bus_req ? {~bus_addr, bus_addr} : 32'hA5A5A5A5;
	assign cnv_rdata = cnv_rd ? {16'hC0DE, cnv_addr} : 32'h5A5A5A5A;
	sbm_seq_end sbm_seq_end_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.link(link), .usr_req(usr_req), .usr_we(usr_we),
		.usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_thread(usr_thread),
		.usr_cnv_only(usr_cnv_only), .usr_disable(usr_disable),
		.usr_busy(usr_busy), .usr_done(usr_done), .usr_err(usr_err),
		.usr_rdata(usr_rdata));
	sbm_master_port sbm_master_port_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.link(link), .cpu_priority(cpu_priority), .cpu_req(cpu_req),
		.cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .bus_req(bus_req),
		.bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .cnv_rd(cnv_rd), .cnv_addr(cnv_addr),
		.cnv_rdata(cnv_rdata));
	sbm_link_props sbm_link_props_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(link.req_valid), .req_ready(link.req_ready),
		.req_addr(link.req_addr), .req_thread(link.req_thread),
		.rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata),
		.rsp_err(link.rsp_err), .rsp_thread(link.rsp_thread),
		.cnv_valid(link.cnv_valid), .cnv_thread(link.cnv_thread),
		.port_disable(link.port_disable));
	always @(posedge clk_sys) begin
		if (bus_req === 1'b1) begin
			if (run == 0) begin
				hist.push_back(bus_addr);
				gq.push_back(gap);
			end
			run++;
			lb_we = bus_we;
			lb_wdata = bus_wdata;
		end else begin
			if (run != 0) begin
				last_len = run;
				nbus++;
			end
			gap = (run != 0) ? 1 : gap + 1;
			run = 0;
		end
		if (cnv_rd === 1'b1) begin
			ncnv++;
		end
	end
	task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(string nm, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %b, seen %b", nm, e, g);
		end
	endtask
	function automatic int exp_len(logic [15:0] a);
		if (a[15:12] == MULTI_WAIT_PAGE || a[15:12] == PROC_ONLY_PAGE) begin
			return int'(WAIT_MULTI) + 1;
		end
		return (a[15:8] == ONE_WAIT_PAGE) ? int'(WAIT_ONE) + 1 : 1;
	endfunction
	task automatic seq_acc(logic we, logic [15:0] a, logic [31:0] d,
		logic [2:0] t);
		int n;
		n = 0;
		@(negedge clk_sys);
		usr_req = 1'b1;
		usr_we = we;
		usr_addr = a;
		usr_wdata = d;
		usr_thread = t;
		@(negedge clk_sys);
		usr_req = 1'b0;
		while (usr_done !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		fails += (n >= 100);
	endtask
	task automatic seq_rd(logic [15:0] a, logic [2:0] t, logic err);
		int nb;
		nb = nbus;
		seq_acc(1'b0, a, 32'h00000000, t);
		chk_bit("seq err", err, usr_err);
		chk_val("bus count", 32'(nb + !err), 32'(nbus));
		if (!err) begin
			chk_val("seq rdata", {~a, a}, usr_rdata);
			chk_val("bus len", 32'(exp_len(a)), 32'(last_len));
		end
	endtask
	task automatic cpu_go(logic we, logic [15:0] a, logic [31:0] d);
		int n;
		n = 0;
		cpu_we = we;
		cpu_addr = a;
		cpu_wdata = d;
		cpu_req = 1'b1;
		@(negedge clk_sys);
		while (cpu_done !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		fails += (n >= 100);
	endtask
	task automatic cnv_rd_chk(logic we, logic [15:0] a, logic err);
		int nc;
		nc = ncnv;
		seq_acc(we, a, 32'h00000000, 3'h6);
		chk_bit("cnv err", err, usr_err);
		chk_val("cnv count", 32'(nc + !err), 32'(ncnv));
		if (!err) begin
			chk_val("cnv rdata", {16'hC0DE, a}, usr_rdata);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#50000;
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		seq_rd(16'h1234, 3'h1, 1'b0);
		seq_rd(16'h0010, 3'h2, 1'b0);
		seq_rd(16'hD004, 3'h3, 1'b0);
		seq_rd(16'hE010, 3'h4, 1'b1);
		seq_acc(1'b1, 16'h2000, 32'h13572468, 3'h5);
		chk_bit("bus we", 1'b1, lb_we);
		chk_val("bus wdata", 32'h13572468, lb_wdata);
		cnv_rd_chk(1'b0, 16'hF123, 1'b0);
		cpu_go(1'b1, 16'h0020, 32'h2468ACE0);
		cpu_req = 1'b0;
		// The run length is only counted one edge after the done pulse.
		@(negedge clk_sys);
		chk_val("cpu wdata", 32'h2468ACE0, lb_wdata);
		chk_val("cpu len", 32'h00000002, 32'(last_len));
		cpu_go(1'b0, 16'hE010, 32'h00000000);
		cpu_req = 1'b0;
		chk_val("cpu rdata", 32'h1FEFE010, cpu_rdata);
		// Pass 0 buffers during the processor access; passes 1 and 2 let
		// both requests meet at one idle edge, so the priority decides.
		for (int p = 0; p < 3; p++) begin
			@(negedge clk_sys);
			cpu_priority = (p == 2);
			hist.delete();
			gq.delete();
			fork
				begin
					cpu_go(1'b0, 16'hD000, 32'h00000000);
					cpu_go(1'b0, 16'h4000, 32'h00000000);
					cpu_req = 1'b0;
				end
				begin
					repeat ((p == 0) ? 1 : 2) @(negedge clk_sys);
					seq_acc(1'b0, 16'h3000, 32'h00000000, 3'h2);
					chk_val("seq rdata", 32'hCFFF3000, usr_rdata);
				end
			join
			chk_val("first", 32'h0000D000, {16'h0, hist[0]});
			chk_val("second", (p == 2) ? 32'h4000 : 32'h3000,
				{16'h0, hist[1]});
			chk_bit("no gap", 1'b1, gq[1] <= 2);
		end
		usr_cnv_only = 1'b1;
		cnv_rd_chk(1'b0, 16'hF004, 1'b0);
		cnv_rd_chk(1'b0, 16'h1000, 1'b1);
		cnv_rd_chk(1'b1, 16'hF004, 1'b1);
		usr_cnv_only = 1'b0;
		usr_disable = 1'b1;
		@(negedge clk_sys);
		usr_disable = 1'b0;
		seq_rd(16'h1000, 3'h7, 1'b1);
		cnv_rd_chk(1'b0, 16'hF000, 1'b1);
		chk_bit("ready", 1'b0, link.req_ready);
		report_and_stop();
	end
endmodule
